// *** bus_handover_pkg.sv ***
package bus_handover_pkg;

  // ---------------------------------------------------------------------------
  // Sizes and reset values
  // ---------------------------------------------------------------------------
  localparam int         ADDR_W_DEF   = 14;
  localparam int         DATA_W_DEF   = 24;
  localparam int         WAIT_W       = 4;
  localparam logic [3:0] WAIT_RESET   = 4'h0;
  localparam logic       GRANT_RESET  = 1'b0;

  // ---------------------------------------------------------------------------
  // Arbiter states, Gray coded along idle -> granted -> hung; hung -> idle flips both bits
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ARB_OWNED   = 2'b00,
    ARB_GRANTED = 2'b01,
    ARB_HUNG    = 2'b11
  } arb_state_t;

  // Request from the core for one external access
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        is_byte_dma_engine;
    logic [2:0]  space;
    logic [13:0] addr;
    logic [23:0] wdata;
    logic [3:0]  waits;
  } mem_req_t;

  // Pin drive group of the external memory interface
  typedef struct packed {
    logic [2:0]  space;
    logic        rd_n;
    logic        wr_n;
    logic [13:0] addr;
    logic [23:0] dout;
    logic        dout_oe;
    logic        pins_oe;
  } mem_pins_t;

  localparam logic [2:0] SPACE_PROG = 3'h0;
  localparam logic [2:0] SPACE_DATA = 3'h1;
  localparam logic [2:0] SPACE_BYTE = 3'h2;
  localparam logic [2:0] SPACE_IO   = 3'h3;
  localparam logic [2:0] SPACE_COMP = 3'h4;

endpackage

// *** access_sequencer.sv ***
`timescale 1ns/1ns
// One external memory access: one strobe cycle plus programmed wait states
module access_sequencer #(
  parameter int WAIT_BITS = bus_handover_pkg::WAIT_W
) (
  input  wire logic                 clk_sys,   // System clock
  input  wire logic                 resetn,    // Synchronous reset
  input  wire logic                 ce,        // Clock enable
  input  wire logic                 start,     // Launch one access
  input  wire logic [WAIT_BITS-1:0] waits,     // Extra wait cycles
  output logic                      busy,      // Access in progress
  output logic                      last       // Final cycle of access
);
  import bus_handover_pkg::*;

  logic [WAIT_BITS-1:0] count_reg;
  logic                 busy_reg;

  if (WAIT_BITS < 1 || WAIT_BITS > 8) begin : g_bad_wait_bits
    $error("WAIT_BITS out of range");
  end

  assign busy = busy_reg;
  assign last = busy_reg && (count_reg == '0);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      busy_reg  <= 1'b0;
      count_reg <= '0;
    end else if (ce) begin
      if (start && !busy_reg) begin
        busy_reg  <= 1'b1;
        count_reg <= waits;
      end else if (last) begin
        busy_reg  <= 1'b0;
      end else if (busy_reg) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule // access_sequencer

// *** external_bus_request_grant.sv ***
`timescale 1ns/1ns
module external_bus_request_grant #(
  parameter int ADDR_W = bus_handover_pkg::ADDR_W_DEF,
  parameter int DATA_W = bus_handover_pkg::DATA_W_DEF
) (
  input  wire logic               clk_sys,             // System clock
  input  wire logic               resetn,              // Sync reset, core only
  input  wire logic               ce,                  // Clock enable
  input  wire logic               bus_request_n,       // External request
  input  wire logic               go_mode,             // Continue while granted
  input  wire bus_handover_pkg::mem_req_t core_req,    // Core access request
  input  wire logic               core_second,         // Another access follows
  input  wire logic [DATA_W-1:0]  data_in,             // Data bus input
  output logic                    core_ack,            // Access taken
  output logic                    core_done,           // Access finished
  output logic [DATA_W-1:0]       core_rdata,          // Read data
  output logic                    core_halt,           // Stop execution
  output logic                    bus_grant_n,         // Bus grant
  output logic                    grant_hang_n,        // Stalled while granted
  output logic                    program_mem_select_n, // Program select
  output logic                    data_mem_select_n,   // Data select
  output logic                    byte_mem_select_n,   // Byte select
  output logic                    composite_select_n,  // Composite select
  output logic                    io_space_select_n,   // I/O select
  output logic                    rd_n,                // Read strobe
  output logic                    wr_n,                // Write strobe
  output logic [ADDR_W-1:0]       addr_out,            // Address bus
  output logic [DATA_W-1:0]       data_out,            // Data bus out
  output logic                    data_oe,             // Data bus enable
  output logic                    ctrl_oe              // Address/strobe enable
);
  import bus_handover_pkg::*;

  if (ADDR_W != ADDR_W_DEF || DATA_W != DATA_W_DEF) begin : g_bad_width
    $error("bus width unsupported");
  end

  // ---------------------------------------------------------------------------
  // Request sampling
  // ---------------------------------------------------------------------------
  logic       req_reg;
  arb_state_t state_reg;
  arb_state_t state_next;
  mem_req_t   cur_reg;
  logic       rd_reg;
  logic       wr_reg;
  logic       sel_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic       done_reg;

  wire seq_busy;
  wire seq_last;
  wire granted   = (state_reg != ARB_OWNED);
  wire req_active = req_reg;
  wire want_bus  = core_req.valid;
  // No access is taken under reset, the sequencer would not run it
  wire start_acc = resetn && want_bus && !granted && !seq_busy && !req_active;

  // ---------------------------------------------------------------------------
  // Arbiter
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ARB_OWNED: begin
        if (req_active && !seq_busy) begin
          state_next = ARB_GRANTED;
        end
      end
      ARB_GRANTED: begin
        if (!req_active) begin
          state_next = ARB_OWNED;
        end else if (want_bus) begin
          state_next = ARB_HUNG;
        end
      end
      ARB_HUNG: begin
        if (!req_active) begin
          state_next = ARB_OWNED;
        end
      end
      default: state_next = ARB_OWNED;
    endcase
  end

  // Arbitration keeps running under reset
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      req_reg   <= !bus_request_n;
      state_reg <= state_next;
    end
  end

  access_sequencer #(
    .WAIT_BITS (WAIT_W)
  ) u_seq (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ce      (ce),
    .start   (start_acc),
    .waits   (core_req.waits),
    .busy    (seq_busy),
    .last    (seq_last)
  );

  // ---------------------------------------------------------------------------
  // Access datapath
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cur_reg   <= '0;
      rd_reg    <= 1'b0;
      wr_reg    <= 1'b0;
      sel_reg   <= 1'b0;
      rdata_reg <= '0;
      done_reg  <= 1'b0;
    end else if (ce) begin
      done_reg <= seq_last;
      if (start_acc) begin
        cur_reg <= core_req;
        sel_reg <= 1'b1;
        rd_reg  <= !core_req.write;
        wr_reg  <= core_req.write;
      end else if (seq_last) begin
        sel_reg <= 1'b0;
        rd_reg  <= 1'b0;
        wr_reg  <= 1'b0;
        if (!cur_reg.write) begin
          rdata_reg <= data_in;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Pin decode
  // ---------------------------------------------------------------------------
  wire drive = !granted;
  wire sel_p = sel_reg && cur_reg.space == SPACE_PROG;
  wire sel_d = sel_reg && cur_reg.space == SPACE_DATA;
  wire sel_b = sel_reg && cur_reg.space == SPACE_BYTE;
  wire sel_i = sel_reg && cur_reg.space == SPACE_IO;
  wire sel_c = sel_reg && cur_reg.space == SPACE_COMP;

  assign ctrl_oe              = drive;
  assign data_oe              = drive && wr_reg;
  assign program_mem_select_n = !sel_p;
  assign data_mem_select_n    = !sel_d;
  assign byte_mem_select_n    = !sel_b;
  assign io_space_select_n    = !sel_i;
  assign composite_select_n   = !sel_c;
  assign rd_n                 = !rd_reg;
  assign wr_n                 = !wr_reg;
  assign addr_out             = cur_reg.addr;
  assign data_out             = cur_reg.wdata;
  assign bus_grant_n          = !granted;
  assign grant_hang_n         = !(state_reg == ARB_HUNG);
  assign core_halt            = granted && (!go_mode || want_bus);
  assign core_ack             = start_acc;
  assign core_done            = done_reg;
  assign core_rdata           = rdata_reg;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_release;
    @(posedge clk_sys) disable iff (!ce)
      (req_active && !seq_busy && state_reg == ARB_OWNED) |=> (!bus_grant_n && !ctrl_oe);
  endproperty
  a_release: assert property (p_release) else $error("bus not released");

  property p_halt;
    @(posedge clk_sys) disable iff (!ce)
      (!bus_grant_n && !go_mode) |-> core_halt;
  endproperty
  a_halt: assert property (p_halt) else $error("core not halted");

  property p_go;
    @(posedge clk_sys) disable iff (!ce)
      (go_mode && !want_bus) |-> !core_halt;
  endproperty
  a_go: assert property (p_go) else $error("core halted in go mode");

  property p_wait_access;
    @(posedge clk_sys) disable iff (!ce)
      seq_busy |-> (bus_grant_n && ctrl_oe);
  endproperty
  a_wait_access: assert property (p_wait_access) else $error("grant during access");

  property p_between;
    @(posedge clk_sys) disable iff (!ce)
      (seq_last && req_active && core_second) |=> (state_reg == ARB_OWNED) ##1 !bus_grant_n;
  endproperty
  a_between: assert property (p_between) else $error("no grant between accesses");

  sequence s_withdraw;
    granted && !req_active;
  endsequence
  property p_return;
    @(posedge clk_sys) disable iff (!ce)
      s_withdraw |=> (bus_grant_n && grant_hang_n && ctrl_oe);
  endproperty
  a_return: assert property (p_return) else $error("bus not returned");

  property p_reset_grant;
    @(posedge clk_sys) disable iff (!ce)
      (!resetn && req_active && !seq_busy) |=> !bus_grant_n;
  endproperty
  a_reset_grant: assert property (p_reset_grant) else $error("grant blocked by reset");

  property p_hang;
    @(posedge clk_sys) disable iff (!ce)
      (state_reg == ARB_GRANTED && req_active && want_bus) |=> !grant_hang_n;
  endproperty
  a_hang: assert property (p_hang) else $error("grant-hang missing");

  property p_sample;
    @(posedge clk_sys) disable iff (!ce)
      ($fell(bus_request_n) && state_reg == ARB_OWNED && !seq_busy && !core_ack)
        |=> ##1 !bus_grant_n;
  endproperty
  a_sample: assert property (p_sample) else $error("request not sampled");

  property p_hang_granted;
    @(posedge clk_sys) disable iff (!ce)
      !grant_hang_n |-> !bus_grant_n;
  endproperty
  a_hang_granted: assert property (p_hang_granted) else $error("grant-hang without grant");

  property p_quiet_granted;
    @(posedge clk_sys) disable iff (!ce)
      !bus_grant_n |-> (rd_n && wr_n && !data_oe && !ctrl_oe);
  endproperty
  a_quiet_granted: assert property (p_quiet_granted) else $error("strobe while granted");

  property p_one_select;
    @(posedge clk_sys) disable iff (!ce)
      $onehot0(~{program_mem_select_n, data_mem_select_n, byte_mem_select_n,
                 composite_select_n, io_space_select_n});
  endproperty
  a_one_select: assert property (p_one_select) else $error("several selects low");

  property p_no_ack_granted;
    @(posedge clk_sys) disable iff (!ce)
      !bus_grant_n |-> !core_ack;
  endproperty
  a_no_ack_granted: assert property (p_no_ack_granted) else $error("access taken while granted");

  property p_grant_stands;
    @(posedge clk_sys) disable iff (!ce)
      (!bus_grant_n && req_active) |=> !bus_grant_n;
  endproperty
  a_grant_stands: assert property (p_grant_stands) else $error("grant dropped early");

  property p_run_when_owned;
    @(posedge clk_sys) disable iff (!ce)
      bus_grant_n |-> !core_halt;
  endproperty
  a_run_when_owned: assert property (p_run_when_owned) else $error("core halted without grant");

  property p_idle_no_grant;
    @(posedge clk_sys) disable iff (!ce)
      (bus_grant_n && !req_active) |=> bus_grant_n;
  endproperty
  a_idle_no_grant: assert property (p_idle_no_grant) else $error("grant without request");

  sequence s_taken;
    core_ack;
  endsequence
  sequence s_strobing;
    (!rd_n || !wr_n) && ctrl_oe;
  endsequence
  property p_taken_strobes;
    @(posedge clk_sys) disable iff (!ce)
      s_taken |=> s_strobing;
  endproperty
  a_taken_strobes: assert property (p_taken_strobes) else $error("access not started");

  sequence s_last_beat;
    seq_last ##1 resetn;
  endsequence
  property p_done_pulse;
    @(posedge clk_sys) disable iff (!ce)
      s_last_beat |-> core_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("access end not flagged");

  // Bus handed back while the core waits: the stalled access goes next
  sequence s_give_back;
    state_reg == ARB_HUNG && !req_active && bus_request_n && resetn && want_bus;
  endsequence
  property p_pending_runs;
    @(posedge clk_sys) disable iff (!ce)
      s_give_back |=> core_ack;
  endproperty
  a_pending_runs: assert property (p_pending_runs) else $error("pending access not run");

endmodule // external_bus_request_grant

// *** bus_master_model.sv ***
`timescale 1ns/1ns
// -----------------------------------------------------------------
// External master: requests the bus, gives way on grant-hang
// -----------------------------------------------------------------
module bus_master_model (
  input  wire logic clk_sys,       // System clock
  input  wire logic want,          // Master needs the bus
  input  wire logic bus_grant_n,   // Grant from device
  input  wire logic grant_hang_n,  // Device stalled
  output logic      bus_request_n, // Request to device
  output logic      owns           // Master drives the bus
);
  logic backed_reg;
  initial begin
    bus_request_n = 1'b1;
    backed_reg    = 1'b0;
  end
  // Non-blocking on the edge: no race with the bench's own drive delay
  always @(posedge clk_sys) begin
    if (!want) begin
      bus_request_n <= 1'b1;
      backed_reg    <= 1'b0;
    end else if (grant_hang_n === 1'b0 && bus_grant_n === 1'b0) begin
      bus_request_n <= 1'b1;
      backed_reg    <= 1'b1;
    end else if (!backed_reg) begin
      bus_request_n <= 1'b0;
    end
  end
  assign owns = (bus_grant_n === 1'b0) && !bus_request_n;
endmodule // bus_master_model

// *** external_bus_request_grant_test.sv ***
`timescale 1ns/1ns
module external_bus_request_grant_test;
  import bus_handover_pkg::*;
  logic        clk_sys = 1'b0, resetn = 1'b0, want = 1'b0;
  logic        go_mode = 1'b0, core_second = 1'b0, ce = 1'b1;
  mem_req_t    core_req = '0;
  logic [23:0] data_in = 24'h5A5A5A;
  logic        core_ack, core_done, core_halt, bus_grant_n, grant_hang_n;
  logic        rd_n, wr_n, data_oe, ctrl_oe, bus_request_n, owns;
  logic [23:0] core_rdata, data_out;
  logic [13:0] addr_out;
  logic [4:0]  sel_n;
  int          err_count = 0;
  int          checks = 0;

  always #20 clk_sys = ~clk_sys;

  external_bus_request_grant dut (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .bus_request_n(bus_request_n),
    .go_mode(go_mode), .core_req(core_req), .core_second(core_second),
    .data_in(data_in), .core_ack(core_ack), .core_done(core_done),
    .core_rdata(core_rdata), .core_halt(core_halt), .bus_grant_n(bus_grant_n),
    .grant_hang_n(grant_hang_n), .program_mem_select_n(sel_n[0]),
    .data_mem_select_n(sel_n[1]), .byte_mem_select_n(sel_n[2]),
    .composite_select_n(sel_n[3]), .io_space_select_n(sel_n[4]), .rd_n(rd_n),
    .wr_n(wr_n), .addr_out(addr_out), .data_out(data_out), .data_oe(data_oe),
    .ctrl_oe(ctrl_oe));

  bus_master_model master (.clk_sys(clk_sys), .want(want), .bus_grant_n(bus_grant_n),
    .grant_hang_n(grant_hang_n), .bus_request_n(bus_request_n), .owns(owns));

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  task tick;
    @(posedge clk_sys);
    #1;
  endtask
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wait_grant(input logic lvl);
    int n;
    n = 0;
    while (bus_grant_n !== lvl && n < 20) begin
      tick;
      n++;
    end
    chk(bus_grant_n, lvl);
  endtask
  task take_access;
    int n;
    n = 0;
    @(negedge clk_sys);
    while (core_ack !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk(core_ack, 1'b1);
    tick;
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task t_idle_grant;
    want = 1'b1;
    tick;
    tick;
    chk(bus_grant_n, 1'b1);
    tick;
    chk(bus_grant_n, 1'b0);
    chk(ctrl_oe, 1'b0);
    chk(data_oe, 1'b0);
    chk(core_halt, 1'b1);
    chk(owns, 1'b1);
    ce = 1'b0;
    want = 1'b0;
    repeat (4) tick;
    chk(bus_grant_n, 1'b0);
    ce = 1'b1;
    wait_grant(1'b1);
    chk(ctrl_oe, 1'b1);
    chk(core_halt, 1'b0);
  endtask
  task t_mid_access;
    int cnt;
    int n;
    int done_n;
    cnt = 0;
    n = 0;
    done_n = 0;
    core_second = 1'b1;
    core_req = '{valid: 1'b1, space: SPACE_DATA, addr: 14'h0123, waits: 4'h3, default: '0};
    take_access;
    chk(24'(addr_out), 24'h000123);
    core_req.addr = 14'h0124;
    want = 1'b1;
    while (bus_grant_n !== 1'b0 && n < 20) begin
      if (rd_n === 1'b0) cnt++;
      if (core_done === 1'b1) done_n++;
      tick;
      n++;
    end
    core_second = 1'b0;
    chk(24'(cnt), 24'h000004);
    chk(24'(done_n), 24'h000001);
    chk(ctrl_oe, 1'b0);
    chk(core_ack, 1'b0);
    chk(rd_n, 1'b1);
    chk(core_rdata, 24'h5A5A5A);
    want = 1'b0;
    wait_grant(1'b1);
    take_access;
    chk(sel_n, 5'h1D);
    chk(24'(addr_out), 24'h000124);
    core_req.valid = 1'b0;
    repeat (6) tick;
  endtask
  task t_go_mode;
    int n;
    n = 0;
    go_mode = 1'b1;
    want = 1'b1;
    wait_grant(1'b0);
    chk(core_halt, 1'b0);
    core_req = '{valid: 1'b1, write: 1'b1, space: SPACE_PROG, addr: 14'h0200,
                 wdata: 24'hC3C3C3, default: '0};
    while (grant_hang_n !== 1'b0 && n < 10) begin
      tick;
      n++;
    end
    chk(grant_hang_n, 1'b0);
    chk(core_halt, 1'b1);
    wait_grant(1'b1);
    chk(grant_hang_n, 1'b1);
    take_access;
    chk({wr_n, data_oe, sel_n[0]}, 3'h2);
    chk(data_out, 24'hC3C3C3);
    core_req.valid = 1'b0;
    want = 1'b0;
    go_mode = 1'b0;
    repeat (6) tick;
  endtask
  task t_reset;
    resetn = 1'b0;
    want = 1'b1;
    wait_grant(1'b0);
    chk(ctrl_oe, 1'b0);
    want = 1'b0;
    wait_grant(1'b1);
    chk(rd_n, 1'b1);
    resetn = 1'b1;
    tick;
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    tick;
    t_idle_grant;
    t_mid_access;
    t_go_mode;
    t_reset;
    end_of_test;
  end
  initial begin
    #100000;
    err_count++;
    end_of_test;
  end
endmodule // external_bus_request_grant_test
